/* File: scsf_consts.svh */
/*
 * constants for the serial control/status flag block: register offsets,
 * field positions, reset values.
 * assumes a plain register port with 8-bit data.
 */
// Contract
// [R1] smart card: tx enable bit allows tx irq
// [R2] tx irq withdrawn by flag clear or disable
// [R3] rx enable bit allows rx irqs
// [R4] rx irqs withdrawn by flag clear or disable
// [R5] normal mode: 00 port, 01 clock, 1X reserved
// [R6] block mode: 00 low, 10 high, x1 clock
// [R7] block mode clock select changes live
// [R8] status flags writable only to zero
// [R9] status meaning depends on smart card select
// [R10] tx empty flag resets to one
// [R11] tx empty forced one while tx disabled
// [R12] tx empty set on buffer-to-shift move
// [R13] tx empty clears on zero after read one
// [R14] dma write to tx buffer clears flag
// [R15] rx full set on completed reception
// [R16] tx irq is flag and enable, each cycle
`ifndef SCSF_CONSTS_SVH
`define SCSF_CONSTS_SVH
`define SCSF_OFS_CTRL      4'h0
`define SCSF_OFS_STAT      4'h1
`define SCSF_OFS_MODE      4'h2
`define SCSF_OFS_IRQ_STAT  4'h3
`define SCSF_OFS_IRQ_MASK  4'h4
`define SCSF_CTRL_TX_IRQ_EN 7
`define SCSF_CTRL_RX_IRQ_EN 6
`define SCSF_CTRL_TX_EN     5
`define SCSF_ST_TX_EMPTY    7
`define SCSF_ST_RX_FULL     6
`define SCSF_ST_OVERRUN     5
`define SCSF_ST_FRAME       4
`define SCSF_ST_PARITY      3
`define SCSF_MODE_BLOCK     0
`define SCSF_MODE_CARD      1
`define SCSF_CTRL_RST      8'h00
`define SCSF_STAT_RST      8'h80
`endif

/* File: scsf_peer.sv */
/* serial unit and peer model: event strobes and a free-running baud level.
   assumes pulse() is called just after a rising edge of clk. */
`timescale 1ns/1ps
module scsf_peer (
    // clock
    input  wire logic       clk,
    // events toward the block: load, dma, done, overrun, framing, parity
    output logic      [5:0] ev,
    output logic            baud_clk
);
    ////////////////////////////////////////////////////////////////////////
    // baud level at an unrelated rate so the pin sync is really exercised
    initial begin
        ev = 6'h00;
        baud_clk = 1'b0;
        forever #130 baud_clk = ~baud_clk;
    end
    // one-cycle strobe; software-side clear handshake is left to the bench
    task automatic pulse(input int idx);
        ev[idx] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask
endmodule

/* File: scsf_pkg.sv */
/*
 * types for the serial control/status flag block.
 * assumes scsf_consts.svh supplies the numbers.
 */
package scsf_pkg;
    typedef enum logic [1:0] {
        SCSF_PIN_PORT,
        SCSF_PIN_CLOCK,
        SCSF_PIN_LOW,
        SCSF_PIN_HIGH
    } scsf_pin_e;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [1:0] mode;
        logic [7:0] flag_seen;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [7:0] rdata;
        logic       tx_irq;
        logic       rx_irq;
        logic       err_irq;
        logic       irq;
        logic       sck_out;
        logic       sck_oe;
        logic [1:0] ev_sync1;
        logic [1:0] ev_sync2;
    } scsf_state_s;
endpackage

/* File: scsf_top.sv */
/*
 * serial control and status flags: interrupt enables, clock pin control
 * and clear-only status flags of the serial unit.
 * assumes one 25 MHz clock, synchronous active-high reset, and that the
 * shifter, receiver and baud generator events arrive on this clock except
 * the baud clock level, which is synchronised here.
 */
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "scsf_consts.svh"

module scsf_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // events from the serial unit (same clock)
    input  wire logic       tx_load_ev,
    input  wire logic       dma_tx_write,
    input  wire logic       rx_done_ev,
    input  wire logic       rx_overrun_ev,
    input  wire logic       rx_frame_err_ev,
    input  wire logic       rx_parity_err_ev,
    // raw baud clock level to be gated onto the pin
    input  wire logic       baud_clk,
    // interrupt requests
    output logic            tx_empty_irq,
    output logic            rx_full_irq,
    output logic            rx_error_irq,
    output logic            irq,
    // serial clock pin
    output logic            sck_out,
    output logic            sck_oe
);
    scsf_pkg::scsf_state_s st_reg;
    scsf_pkg::scsf_state_s st_next;
    scsf_pkg::scsf_pin_e   pin_sel;
    logic [7:0]            wclr;
    logic [3:0]            ev;
    logic                  err_any;

    ////////////////////////////////////////////////////////////////////////
    // clock pin selection from mode and clock enable field
    always_comb begin
        if (st_reg.mode[`SCSF_MODE_BLOCK]) begin
            // block mode: selection is decoded live, no lock-out [R6] [R7]
            case (st_reg.ctrl[1:0])
                2'h0:    pin_sel = scsf_pkg::SCSF_PIN_LOW;
                2'h2:    pin_sel = scsf_pkg::SCSF_PIN_HIGH;
                default: pin_sel = scsf_pkg::SCSF_PIN_CLOCK;
            endcase
        end else begin
            // reserved codes fall back to the port pin [R5]
            case (st_reg.ctrl[1:0])
                2'h1:    pin_sel = scsf_pkg::SCSF_PIN_CLOCK;
                default: pin_sel = scsf_pkg::SCSF_PIN_PORT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        wclr = 8'h00;
        err_any = 1'b0;
        // baud clock is from another domain: two flops before use
        st_next.ev_sync1 = {baud_clk, 1'b0};
        st_next.ev_sync2 = st_reg.ev_sync1;
        st_next.rdata = 8'h00;

        if (rd) begin
            case (addr)
                `SCSF_OFS_CTRL:     st_next.rdata = st_reg.ctrl;
                `SCSF_OFS_STAT:     st_next.rdata = st_reg.stat;
                `SCSF_OFS_MODE:     st_next.rdata = {6'h00, st_reg.mode};
                `SCSF_OFS_IRQ_STAT: st_next.rdata = {4'h0, st_reg.irq_stat};
                `SCSF_OFS_IRQ_MASK: st_next.rdata = {4'h0, st_reg.irq_mask};
                default:            st_next.rdata = 8'h00;
            endcase
            // remember which flags were seen as one [R13] [R4]
            if (addr == `SCSF_OFS_STAT)
                st_next.flag_seen = st_reg.flag_seen | st_reg.stat;
        end

        if (wr) begin
            case (addr)
                `SCSF_OFS_CTRL: st_next.ctrl = wdata;
                // zero clears only a flag already read as one; ones ignored [R8] [R13]
                `SCSF_OFS_STAT: wclr = ~wdata & st_reg.flag_seen & 8'hf8;
                `SCSF_OFS_MODE: st_next.mode = wdata[1:0];
                `SCSF_OFS_IRQ_STAT: st_next.irq_stat = st_reg.irq_stat & ~wdata[3:0];
                `SCSF_OFS_IRQ_MASK: st_next.irq_mask = wdata[3:0];
                default: ;
            endcase
            if (addr == `SCSF_OFS_STAT)
                st_next.flag_seen = st_reg.flag_seen & ~wclr;
            // low bits are not clear-only flags; stored as written
            if (addr == `SCSF_OFS_STAT)
                st_next.stat[2:0] = wdata[2:0];
        end

        st_next.stat[7:3] = st_reg.stat[7:3] & ~wclr[7:3];
        if (dma_tx_write)
            st_next.stat[`SCSF_ST_TX_EMPTY] = 1'b0; // [R14]
        if (tx_load_ev)
            st_next.stat[`SCSF_ST_TX_EMPTY] = 1'b1; // set beats clear [R12]
        if (!st_next.ctrl[`SCSF_CTRL_TX_EN])
            st_next.stat[`SCSF_ST_TX_EMPTY] = 1'b1; // [R11]
        if (rx_done_ev)
            st_next.stat[`SCSF_ST_RX_FULL] = 1'b1; // [R15]
        if (rx_overrun_ev)
            st_next.stat[`SCSF_ST_OVERRUN] = 1'b1;
        if (rx_frame_err_ev)
            st_next.stat[`SCSF_ST_FRAME] = 1'b1;
        if (rx_parity_err_ev)
            st_next.stat[`SCSF_ST_PARITY] = 1'b1;

        // in smart card mode the error-signal flag replaces framing [R9]
        err_any = st_next.stat[`SCSF_ST_OVERRUN] | st_next.stat[`SCSF_ST_PARITY]
                | (st_next.stat[`SCSF_ST_FRAME] & ~st_next.mode[`SCSF_MODE_CARD]);
        if (st_next.mode[`SCSF_MODE_CARD])
            err_any = err_any | st_next.stat[`SCSF_ST_FRAME];

        // irq lines are flag and enable, so clearing either withdraws [R16] [R1] [R2]
        st_next.tx_irq  = st_next.stat[`SCSF_ST_TX_EMPTY] & st_next.ctrl[`SCSF_CTRL_TX_IRQ_EN];
        // both rx requests share one enable [R3] [R4]
        st_next.rx_irq  = st_next.stat[`SCSF_ST_RX_FULL] & st_next.ctrl[`SCSF_CTRL_RX_IRQ_EN];
        st_next.err_irq = err_any & st_next.ctrl[`SCSF_CTRL_RX_IRQ_EN];

        // sticky event bits, set wins over a write-one clear
        ev = {rx_overrun_ev | rx_frame_err_ev | rx_parity_err_ev,
              rx_done_ev, dma_tx_write, tx_load_ev};
        st_next.irq_stat = st_next.irq_stat | ev;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

        // pin drive
        case (pin_sel)
            scsf_pkg::SCSF_PIN_CLOCK: begin
                st_next.sck_out = st_reg.ev_sync2[1];
                st_next.sck_oe  = 1'b1;
            end
            scsf_pkg::SCSF_PIN_LOW: begin
                st_next.sck_out = 1'b0;
                st_next.sck_oe  = 1'b1;
            end
            scsf_pkg::SCSF_PIN_HIGH: begin
                st_next.sck_out = 1'b1;
                st_next.sck_oe  = 1'b1;
            end
            default: begin
                st_next.sck_out = 1'b0;
                st_next.sck_oe  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; status resets with tx empty set [R10]
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg      <= '0;
            st_reg.ctrl <= `SCSF_CTRL_RST;
            st_reg.stat <= `SCSF_STAT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign rdata        = st_reg.rdata;
    assign tx_empty_irq = st_reg.tx_irq;
    assign rx_full_irq  = st_reg.rx_irq;
    assign rx_error_irq = st_reg.err_irq;
    assign irq          = st_reg.irq;
    assign sck_out      = st_reg.sck_out;
    assign sck_oe       = st_reg.sck_oe;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_tx_irq;
        @(posedge clk) disable iff (rst)
        tx_empty_irq == (st_reg.stat[7] & st_reg.ctrl[7]);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq not flag and enable"); // [R16]

    property p_tx_irq_off;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h0 && !wdata[7]) |=> !tx_empty_irq;
    endproperty
    a_tx_irq_off: assert property (p_tx_irq_off) else $error("tx irq kept after disable"); // [R2]

    property p_rx_gate;
        @(posedge clk) disable iff (rst)
        !st_reg.ctrl[6] |-> (!rx_full_irq && !rx_error_irq);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx irq without enable"); // [R3]

    property p_no_set;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h1 && !rx_done_ev && !st_reg.stat[6]) |=> !st_reg.stat[6];
    endproperty
    a_no_set: assert property (p_no_set) else $error("status flag set by write"); // [R8]

    property p_tx_disabled;
        @(posedge clk) disable iff (rst)
        !st_reg.ctrl[5] |-> st_reg.stat[7];
    endproperty
    a_tx_disabled: assert property (p_tx_disabled) else $error("tx empty low while disabled"); // [R11]

    property p_load;
        @(posedge clk) disable iff (rst)
        tx_load_ev |=> st_reg.stat[7];
    endproperty
    a_load: assert property (p_load) else $error("tx empty not set on load"); // [R12]

    property p_blind_clear;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h1 && !st_reg.flag_seen[7] && !dma_tx_write) |=> st_reg.stat[7]
            || $past(st_reg.stat[7]) == 1'b0;
    endproperty
    a_blind_clear: assert property (p_blind_clear) else $error("blind clear took"); // [R13]

    property p_dma_clear;
        @(posedge clk) disable iff (rst)
        (dma_tx_write && !tx_load_ev && st_reg.ctrl[5] && !wr) |=> !st_reg.stat[7];
    endproperty
    a_dma_clear: assert property (p_dma_clear) else $error("dma write kept tx empty"); // [R14]

    property p_rx_done;
        @(posedge clk) disable iff (rst)
        rx_done_ev |=> st_reg.stat[6];
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx full not set"); // [R15]

    sequence s_gm_low;
        st_reg.mode[0] && st_reg.ctrl[1:0] == 2'h0;
    endsequence
    property p_fix_low;
        @(posedge clk) disable iff (rst)
        s_gm_low ##1 s_gm_low |-> (sck_oe && !sck_out);
    endproperty
    a_fix_low: assert property (p_fix_low) else $error("pin not held low"); // [R6]

    sequence s_gm_high;
        st_reg.mode[0] && st_reg.ctrl[1:0] == 2'h2;
    endsequence
    property p_fix_high;
        @(posedge clk) disable iff (rst)
        s_gm_high ##1 s_gm_high |-> (sck_oe && sck_out);
    endproperty
    a_fix_high: assert property (p_fix_high) else $error("pin not held high"); // [R6]

    sequence s_gm_clk;
        st_reg.mode[0] && st_reg.ctrl[0];
    endsequence
    property p_clk_pin;
        @(posedge clk) disable iff (rst)
        s_gm_clk ##1 s_gm_clk |-> (sck_oe && sck_out == $past(st_reg.ev_sync2[1]));
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("block mode clock not on pin"); // [R6] [R7]

    sequence s_norm_port;
        !st_reg.mode[0] && st_reg.ctrl[1:0] != 2'h1;
    endsequence
    property p_port_pin;
        @(posedge clk) disable iff (rst)
        s_norm_port ##1 s_norm_port |-> !sck_oe;
    endproperty
    a_port_pin: assert property (p_port_pin) else $error("pin driven while free"); // [R5]

    sequence s_norm_clk;
        !st_reg.mode[0] && st_reg.ctrl[1:0] == 2'h1;
    endsequence
    property p_norm_clk;
        @(posedge clk) disable iff (rst)
        s_norm_clk ##1 s_norm_clk |-> sck_oe;
    endproperty
    a_norm_clk: assert property (p_norm_clk) else $error("clock output not driven"); // [R5]

    ////////////////////////////////////////////////////////////////////////
    // interrupt lines, flag clears and the read port
    property p_rx_irq;
        @(posedge clk) disable iff (rst)
        rx_full_irq == (st_reg.stat[6] & st_reg.ctrl[6]);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq not flag and enable"); // [R3]

    // any of the three error flags raises the error line in either mode
    property p_err_irq;
        @(posedge clk) disable iff (rst)
        rx_error_irq == ((|st_reg.stat[5:3]) & st_reg.ctrl[6]);
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq mismatch"); // [R3] [R9]

    property p_rx_irq_off;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h0 && !wdata[6]) |=> (!rx_full_irq && !rx_error_irq);
    endproperty
    a_rx_irq_off: assert property (p_rx_irq_off) else $error("rx irq not withdrawn"); // [R4]

    property p_rx_flag_clear;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h1 && st_reg.flag_seen[6] && !wdata[6] && !rx_done_ev)
            |=> !rx_full_irq;
    endproperty
    a_rx_flag_clear: assert property (p_rx_flag_clear) else $error("rx full kept"); // [R4]

    property p_tx_clear;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h1 && st_reg.flag_seen[7] && !wdata[7] && st_reg.ctrl[5]
            && !tx_load_ev) |=> !st_reg.stat[7];
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("tx empty clear lost"); // [R13]

    // writing ones to the flags must leave every flag where it was
    property p_ones_kept;
        @(posedge clk) disable iff (rst)
        (wr && addr == 4'h1 && wdata[7:3] == 5'h1f && !tx_load_ev && !dma_tx_write
            && !rx_done_ev && !rx_overrun_ev && !rx_frame_err_ev && !rx_parity_err_ev)
            |=> st_reg.stat[7:3] == $past(st_reg.stat[7:3]);
    endproperty
    a_ones_kept: assert property (p_ones_kept) else $error("flag moved on write one"); // [R8]

    property p_reset_flag;
        @(posedge clk)
        $fell(rst) |-> (st_reg.stat == 8'h80 && !tx_empty_irq && !sck_oe);
    endproperty
    a_reset_flag: assert property (p_reset_flag) else $error("bad state after reset"); // [R10]

    property p_read_stat;
        @(posedge clk) disable iff (rst)
        (rd && addr == 4'h1) |=> rdata == $past(st_reg.stat);
    endproperty
    a_read_stat: assert property (p_read_stat) else $error("status read wrong");

    // read data only stand in the cycle after the strobe
    property p_read_idle;
        @(posedge clk) disable iff (rst)
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without read");

    property p_irq_sum;
        @(posedge clk) disable iff (rst)
        irq == (|(st_reg.irq_stat & st_reg.irq_mask));
    endproperty
    a_irq_sum: assert property (p_irq_sum) else $error("summary irq mismatch");

    property p_sticky;
        @(posedge clk) disable iff (rst)
        rx_done_ev |=> st_reg.irq_stat[2];
    endproperty
    a_sticky: assert property (p_sticky) else $error("rx done event not kept");
endmodule

/* File: scsf_top_tb.sv */
/* self-checking bench for the serial control/status flag block.
   assumes the register map and pin encoding of the block. */
`timescale 1ns/1ps
module scsf_top_tb;
    logic       clk, rst, wr, rd, baud_clk;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [5:0] ev;
    logic       tx_empty_irq, rx_full_irq, rx_error_irq, irq, sck_out, sck_oe;
    int         n_errors = 0;
    int         tests_run = 0;
    int         hit, ones;

    ////////////////////////////////////////////////////////////////////////
    // design and far side
    scsf_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_load_ev(ev[0]), .dma_tx_write(ev[1]), .rx_done_ev(ev[2]),
        .rx_overrun_ev(ev[3]), .rx_frame_err_ev(ev[4]), .rx_parity_err_ev(ev[5]),
        .baud_clk(baud_clk), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe));
    scsf_peer peer (.clk(clk), .ev(ev), .baud_clk(baud_clk));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // trailing #1 lets the taking edge's updates land before any check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic ev_pulse(input int i);
        @(posedge clk);
        peer.pulse(i);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h1, 8'h80);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h9, 8'h00);
        wr_reg(4'h1, 8'h00);
        rd_reg(4'h1, 8'h80);
        wr_reg(4'h0, 8'ha0);
        chk({7'h00, tx_empty_irq}, 8'h01);
        wr_reg(4'h1, 8'h00);
        chk({7'h00, tx_empty_irq}, 8'h00);
        wr_reg(4'h1, 8'hf8);
        rd_reg(4'h1, 8'h00);
        ev_pulse(0);
        chk({7'h00, tx_empty_irq}, 8'h01);
        wr_reg(4'h1, 8'h00);
        rd_reg(4'h1, 8'h80);
        ev_pulse(1);
        chk({7'h00, tx_empty_irq}, 8'h00);
        ev_pulse(0);
        wr_reg(4'h0, 8'h20);
        chk({7'h00, tx_empty_irq}, 8'h00);
        // receive side with both enables in play
        wr_reg(4'h0, 8'h60);
        ev_pulse(2);
        chk({7'h00, rx_full_irq}, 8'h01);
        rd_reg(4'h1, 8'hc0);
        wr_reg(4'h1, 8'h80);
        chk({7'h00, rx_full_irq}, 8'h00);
        wr_reg(4'h2, 8'h02);
        ev_pulse(4);
        chk({7'h00, rx_error_irq}, 8'h01);
        wr_reg(4'h0, 8'h20);
        chk({7'h00, rx_error_irq}, 8'h00);
        ev_pulse(3);
        chk({7'h00, rx_error_irq}, 8'h00);
        // sticky events, mask and the summary line
        wr_reg(4'h3, 8'h0f);
        rd_reg(4'h3, 8'h00);
        chk({7'h00, irq}, 8'h00);
        ev_pulse(2);
        rd_reg(4'h3, 8'h04);
        hit = 0;
        for (int m = 0; m < 2; m++) begin
            wr_reg(4'h4, m ? 8'h0f : 8'h00);
            hit += (irq === 1'b1);
        end
        chk(8'(hit), 8'h01);
        wr_reg(4'h3, 8'h04);
        chk({7'h00, irq}, 8'h00);
        // pin selection switched live in both modes
        for (int g = 0; g < 2; g++) begin
            wr_reg(4'h2, 8'(g));
            for (int s = 0; s < 4; s++) begin
                wr_reg(4'h0, 8'h20 | 8'(s));
                @(posedge clk);
                #1;
                chk({7'h00, sck_oe}, (g == 1 || s == 1) ? 8'h01 : 8'h00);
                if (g == 1 && s[0] == 1'b0) chk({7'h00, sck_out}, 8'(s >> 1));
                if ((g == 1 || s == 1) && s[0] == 1'b1) begin
                    ones = 0;
                    repeat (20) begin
                        @(posedge clk);
                        #1;
                        ones += (sck_out === 1'b1);
                    end
                    chk(8'(ones > 0 && ones < 20), 8'h01);
                end
            end
        end
        final_report();
    end
endmodule
